// ---- logic/serial_rx_pkg.sv ----
// Shared constants and types for the serial receiver.
`default_nettype none
package serial_rx_pkg;
    localparam int DATA_W_MAX = 8;
    localparam int CHAR_SIZE_W = 3;
    localparam int FIFO_DEPTH_DOC = 16;
    localparam int BUF_CHARS = 2;
    localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
    localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
    // First of the three voting samples, numbering the first low sample as one
    localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;
    localparam logic [2:0] SYNC_RESET = 3'h7;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA = 4'b0100,
        ST_STOP = 4'b1000
    } rx_state_e;
endpackage
`default_nettype wire

// ---- logic/serial_rx_fifo.sv ----
// Parameterised FIFO with valid and ready on both sides and a flush.
`default_nettype none
module serial_rx_fifo
    import serial_rx_pkg::*;
#(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_flush,
    // Write side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Read side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_s;
    fifo_s st_reg;
    fifo_s st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;
    assign o_in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (st_reg.cnt != '0);
    assign o_out_data = mem[st_reg.rd];
    assign push = i_in_valid && o_in_ready && !i_flush;
    assign pop = o_out_valid && i_out_ready && !i_flush;
    always_comb begin
        st_next = st_reg;
        if (i_flush) begin
            st_next = '0;
        end else begin
            if (push) begin
                st_next.wr = st_reg.wr + 1'b1;
            end
            if (pop) begin
                st_next.rd = st_reg.rd + 1'b1;
            end
            st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[st_reg.wr] <= i_in_data;
        end
    end
endmodule
`default_nettype wire

// ---- logic/serial_receiver.sv ----
// Asynchronous serial receiver with two-character buffer and status flags.
// What this block does
// - Complete flag high while buffer holds characters
// - Disabling receiver flushes buffer, flag reads zero
// - Interrupt request is level, follows complete flag
// - Error status stored with its character
// - Error flags not writable by software
// - Error flags raise no interrupt
// - Frame error from first stop bit only
// - Overrun: buffer full, shifter full, new start
// - Overrun clears on successful transfer to buffer
// - Parity checked only when enable bit set
// - Parity mismatch stored with character
// - Parity error reads zero when checking disabled
// - Parity error valid until data read
// - Disable is immediate, frame abandoned
// - Disabled receiver releases pin override
// - Data read advances buffer and flags
// - Sixteen samples per bit, eight at double speed
// - Falling edge starts detection, first low sample one
// - Start bit voted on samples 8-10 or 4-6
// - Reject returns to search, accept resynchronises
// - Frame moved to buffer after first stop bit
// - Unused high data bits read zero
// - Bits decided by three-sample majority vote
`default_nettype none
module serial_receiver
    import serial_rx_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DOC,
    parameter int BUF_LIMIT = BUF_CHARS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Serial line
    input wire logic i_serial_input_pin,
    output logic o_pin_override,
    // Configuration
    input wire logic i_receiver_enable_bit,
    input wire logic i_rx_complete_irq_enable,
    input wire logic i_parity_enable_bit,
    input wire logic i_parity_odd_select,
    input wire logic i_stop_bit_count_select,
    input wire logic i_double_speed_bit,
    input wire logic [CHAR_SIZE_W-1:0] i_char_size,
    input wire logic [15:0] i_baud_divisor,
    // Status and data
    input wire logic i_data_read,
    output logic [DATA_W_MAX-1:0] o_serial_data_register,
    output logic o_rx_complete_flag,
    output logic o_frame_error_flag,
    output logic o_overrun_flag,
    output logic o_parity_error_flag,
    output logic o_rx_complete_irq,
    // Buffer back-pressure seen by the shifter
    output logic o_buffer_ready
);
    localparam int ENTRY_W = DATA_W_MAX + 3;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    typedef struct packed {
        logic [2:0] sync;
        logic line_prev;
        logic armed;
        logic [15:0] div;
        rx_state_e state;
        logic [4:0] samp;
        logic [2:0] votes;
        logic [3:0] bit_idx;
        logic [DATA_W_MAX-1:0] shift;
        logic par_bit;
        logic par_en;
        logic par_odd;
        logic frame_err;
        logic held;
        logic [ENTRY_W-1:0] held_entry;
        logic overrun_pend;
        logic [CW-1:0] count;
    } rx_s;

    rx_s st_reg;
    rx_s st_next;

    logic line;
    logic tick;
    logic [4:0] spb;
    logic [4:0] vote_first;
    logic vote_bit;
    logic [3:0] data_bits;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [ENTRY_W-1:0] fifo_out;
    logic push;
    logic pop;
    logic flush;
    logic buf_full;
    logic par_calc;

    // Line level once second and third stage agree
    assign line = (st_reg.sync[1] == st_reg.sync[2]) ? st_reg.sync[2] : st_reg.line_prev;
    assign tick = (st_reg.div == 16'h0000);
    assign spb = i_double_speed_bit ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
    assign vote_first = i_double_speed_bit ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
    assign data_bits = 4'(i_char_size) + 4'h5;
    assign vote_bit = (st_reg.votes[0] & st_reg.votes[1]) | (st_reg.votes[0] & st_reg.votes[2]) |
                      (st_reg.votes[1] & st_reg.votes[2]);
    assign flush = !i_receiver_enable_bit;
    // Disabled receiver holds nothing, so it never reports full
    assign buf_full = !flush && ((st_reg.count >= CW'(BUF_LIMIT)) || !fifo_in_ready);
    assign pop = i_data_read && fifo_out_valid && !flush;
    assign push = st_reg.held && !buf_full && !flush;
    assign o_buffer_ready = !buf_full;
    assign par_calc = (^st_reg.shift) ^ st_reg.par_odd;
    // Entry: {parity error, overrun, frame error, data}

    serial_rx_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_flush(flush),
        .i_in_valid(push),
        .i_in_data(st_reg.held_entry),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out),
        .i_out_ready(pop)
    );

    always_comb begin
        st_next = st_reg;
        st_next.sync = {st_reg.sync[1:0], i_serial_input_pin};
        st_next.line_prev = line;
        st_next.div = tick ? i_baud_divisor : st_reg.div - 16'h0001;
        st_next.count = st_reg.count + CW'(push) - CW'(pop);
        if (push) begin
            st_next.held = 1'b0;
        end
        if (tick) begin
            case (st_reg.state)
                ST_IDLE: begin
                    if (line) begin
                        st_next.armed = 1'b1;
                    end else if (st_reg.armed) begin
                        // This tick is sample one, the next is sample two
                        st_next.armed = 1'b0;
                        st_next.samp = 5'h02;
                        st_next.votes = 3'h0;
                        st_next.state = ST_START;
                        if (buf_full && st_reg.held) begin
                            st_next.overrun_pend = 1'b1;
                        end
                    end
                end
                ST_START: begin
                    st_next.samp = st_reg.samp + 5'h01;
                    if (st_reg.samp >= vote_first && st_reg.samp < vote_first + 5'h03) begin
                        st_next.votes = {st_reg.votes[1:0], line};
                    end
                    if (st_reg.samp == vote_first + 5'h03) begin
                        if (vote_bit) begin
                            st_next.state = ST_IDLE;
                        end else begin
                            st_next.state = ST_DATA;
                            st_next.samp = vote_first + 5'h04;
                            st_next.bit_idx = BIT_CNT_RESET;
                            st_next.shift = '0;
                            st_next.par_en = i_parity_enable_bit;
                            st_next.par_odd = i_parity_odd_select;
                        end
                    end
                end
                ST_DATA, ST_STOP: begin
                    st_next.samp = (st_reg.samp == spb) ? 5'h01 : st_reg.samp + 5'h01;
                    if (st_reg.samp >= vote_first && st_reg.samp < vote_first + 5'h03) begin
                        st_next.votes = {st_reg.votes[1:0], line};
                    end
                    if (st_reg.samp == vote_first + 5'h03 && st_reg.state == ST_DATA) begin
                        if (st_reg.bit_idx < data_bits) begin
                            st_next.shift[st_reg.bit_idx[2:0]] = vote_bit;
                        end else begin
                            st_next.par_bit = vote_bit;
                        end
                        if (st_reg.bit_idx + 4'h1 == data_bits + 4'(st_reg.par_en)) begin
                            st_next.state = ST_STOP;
                        end
                        st_next.bit_idx = st_reg.bit_idx + 4'h1;
                    end
                    if (st_reg.samp == vote_first + 5'h03 && st_reg.state == ST_STOP) begin
                        st_next.state = ST_IDLE;
                        if (!st_reg.held || push) begin
                            st_next.held = 1'b1;
                            st_next.held_entry = {st_reg.par_en & (par_calc != st_reg.par_bit),
                                                  st_reg.overrun_pend, ~vote_bit, st_reg.shift};
                            st_next.overrun_pend = 1'b0;
                        end else begin
                            st_next.overrun_pend = 1'b1;
                        end
                    end
                end
                default: begin
                    st_next.state = ST_IDLE;
                end
            endcase
        end
        if (flush) begin
            st_next.state = ST_IDLE;
            st_next.held = 1'b0;
            st_next.overrun_pend = 1'b0;
            st_next.count = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg <= '0;
            st_reg.sync <= SYNC_RESET;
            st_reg.line_prev <= 1'b1;
            st_reg.div <= BAUD_DIV_RESET;
            st_reg.state <= ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rx_complete_flag = fifo_out_valid && i_receiver_enable_bit;
    assign o_rx_complete_irq = o_rx_complete_flag && i_rx_complete_irq_enable;
    assign o_pin_override = i_receiver_enable_bit;
    assign o_serial_data_register = o_rx_complete_flag ? fifo_out[DATA_W_MAX-1:0] : '0;
    assign o_frame_error_flag = o_rx_complete_flag && fifo_out[DATA_W_MAX];
    assign o_overrun_flag = o_rx_complete_flag && fifo_out[DATA_W_MAX+1];
    assign o_parity_error_flag = o_rx_complete_flag && fifo_out[DATA_W_MAX+2] &&
                                 i_parity_enable_bit;
endmodule
`default_nettype wire

// ---- test/serial_rx_sva.sv ----
// Port assertions for the serial receiver.
`default_nettype none
module serial_rx_sva
    import serial_rx_pkg::*;
(
    // Observed ports
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_receiver_enable_bit,
    input wire logic i_rx_complete_irq_enable,
    input wire logic i_parity_enable_bit,
    input wire logic i_data_read,
    input wire logic [DATA_W_MAX-1:0] o_serial_data_register,
    input wire logic o_rx_complete_flag,
    input wire logic o_overrun_flag,
    input wire logic o_parity_error_flag,
    input wire logic o_rx_complete_irq,
    input wire logic o_pin_override,
    input wire logic o_buffer_ready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_irq_level: assert property (
        o_rx_complete_irq == (o_rx_complete_flag && i_rx_complete_irq_enable))
        else $error("irq not flag and enable");
    a_disable_empty: assert property (
        !i_receiver_enable_bit |-> !o_rx_complete_flag) else $error("flag while disabled");
    a_pin_release: assert property (
        o_pin_override == i_receiver_enable_bit) else $error("override wrong");
    a_parity_off: assert property (
        !i_parity_enable_bit |-> !o_parity_error_flag) else $error("parity flag while off");
    a_head_hold: assert property (
        o_rx_complete_flag && !i_data_read && i_receiver_enable_bit ##1 i_receiver_enable_bit
        |-> o_rx_complete_flag && $stable(o_serial_data_register) && $stable(o_overrun_flag))
        else $error("head changed without read");
    a_empty_ready: assert property (
        !o_rx_complete_flag |-> o_buffer_ready) else $error("empty buffer not ready");
    a_read_frees: assert property (
        !o_buffer_ready && i_data_read |=> o_buffer_ready) else $error("read did not free");
    a_rise_enabled: assert property (
        $rose(o_rx_complete_flag) |-> $past(i_receiver_enable_bit, 8))
        else $error("character from disabled time");
    c_char: cover property ($rose(o_rx_complete_flag));
    c_overrun: cover property (o_overrun_flag && i_data_read);
    c_parity: cover property (o_parity_error_flag && i_data_read);
endmodule
bind serial_receiver serial_rx_sva u_sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_receiver_enable_bit(i_receiver_enable_bit), .i_data_read(i_data_read),
    .i_rx_complete_irq_enable(i_rx_complete_irq_enable),
    .i_parity_enable_bit(i_parity_enable_bit), .o_overrun_flag(o_overrun_flag),
    .o_serial_data_register(o_serial_data_register), .o_rx_complete_flag(o_rx_complete_flag),
    .o_parity_error_flag(o_parity_error_flag), .o_rx_complete_irq(o_rx_complete_irq),
    .o_pin_override(o_pin_override), .o_buffer_ready(o_buffer_ready));
`default_nettype wire

// ---- test/serial_tx_model.sv ----
// Remote transmitter model driving the serial line.
`default_nettype none
module serial_tx_model (
    // Clock and line
    input wire logic i_clk,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_line = 1'b1;
    task automatic put(input logic v, input int spb);
        o_line = v;
        repeat (spb) @(negedge i_clk);
    endtask
    task automatic send(input logic [7:0] d, input int n, input logic pe, input logic odd,
        input logic bad, input logic stop, input int spb);
        logic p;
        p = ^(d & 8'(~(8'hFF << n))) ^ odd ^ bad;
        put(1'b0, spb);
        for (int i = 0; i < n; i++) put(d[i], spb);
        if (pe) put(p, spb);
        put(stop, spb);
        put(1'b1, spb);
    endtask
    // Short low pulse that must be rejected
    task automatic glitch();
        put(1'b0, 3);
        put(1'b1, 40);
    endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the serial receiver.
`default_nettype none
module testbench import serial_rx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, irqen = 1'b1, pen = 1'b0, odd = 1'b0;
    logic ds = 1'b0, rd = 1'b0, line, ovr, flag, fe, dor, pe, irq, rdy;
    logic [2:0] csz = 3'h3;
    logic [7:0] dat, d;
    logic [2:0] st;
    logic seen;
    int miscompares = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    serial_receiver uut (.i_clk(clk), .i_reset_n(rst_n), .i_serial_input_pin(line),
        .o_pin_override(ovr), .i_receiver_enable_bit(en), .i_rx_complete_irq_enable(irqen),
        .i_parity_enable_bit(pen), .i_parity_odd_select(odd), .i_stop_bit_count_select(1'b1),
        .i_double_speed_bit(ds), .i_char_size(csz), .i_baud_divisor(16'h0000),
        .i_data_read(rd), .o_serial_data_register(dat), .o_rx_complete_flag(flag),
        .o_frame_error_flag(fe), .o_overrun_flag(dor), .o_parity_error_flag(pe),
        .o_rx_complete_irq(irq), .o_buffer_ready(rdy));
    serial_tx_model tx (.i_clk(clk), .o_line(line));
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wait_flag();
        int n;
        n = 0;
        while (flag !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 600) begin
                miscompares++;
                $display("ERROR %0t no character", $time);
                give_verdict();
            end
        end
    endtask
    task automatic read();
        st = {fe, dor, pe};
        d = dat;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
    endtask
    task automatic snd(input logic [7:0] v, input int n, input logic bad, input logic stop);
        tx.send(v, n, pen, odd, bad, stop, ds ? 8 : 16);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(flag, 1'b0);
        chk(ovr, 1'b1);
        chk({5'h00, fe, dor, pe}, 8'h00);
        $display("test 1 done");
        pen = 1'b1;
        for (int k = 0; k < 4; k++) begin
            odd = k[0];
            snd(8'h5A, 8, k[1], 1'b1);
            wait_flag();
            chk(irq, 1'b1);
            read();
            chk(d, 8'h5A);
            chk(st, {2'b00, k[1]});
        end
        snd(8'h5A, 8, 1'b1, 1'b1);
        wait_flag();
        pen = 1'b0;
        @(negedge clk);
        chk(pe, 1'b0);
        read();
        $display("test 2 done");
        snd(8'h3C, 8, 1'b0, 1'b0);
        wait_flag();
        pen = 1'b1;
        @(negedge clk);
        chk(pe, 1'b0);
        pen = 1'b0;
        read();
        chk(st, 3'h4);
        ds = 1'b1;
        csz = 3'h0;
        snd(8'hFF, 5, 1'b0, 1'b1);
        wait_flag();
        read();
        chk(d, 8'h1F);
        ds = 1'b0;
        csz = 3'h3;
        $display("test 3 done");
        irqen = 1'b0;
        seen = 1'b0;
        for (int k = 1; k < 5; k++) snd(8'(k * 17), 8, 1'b0, 1'b1);
        chk(rdy, 1'b0);
        for (int k = 0; k < 5 && flag === 1'b1; k++) begin
            chk(irq, 1'b0);
            read();
            if (k == 0) chk({st, d[4:0]}, 8'h11);
            seen = seen | st[1];
        end
        chk(seen, 1'b0);
        chk(flag, 1'b0);
        // Lost frame is reported on the next stored character
        snd(8'h55, 8, 1'b0, 1'b1);
        wait_flag();
        read();
        chk(st, 3'h2);
        snd(8'h56, 8, 1'b0, 1'b1);
        wait_flag();
        read();
        chk(st, 3'h0);
        $display("test 4 done");
        irqen = 1'b1;
        snd(8'h66, 8, 1'b0, 1'b1);
        wait_flag();
        en = 1'b0;
        @(negedge clk);
        chk(flag, 1'b0);
        chk(ovr, 1'b0);
        fork
            begin
                repeat (40) @(negedge clk);
                en = 1'b0;
            end
        join_none
        en = 1'b1;
        snd(8'h77, 8, 1'b0, 1'b1);
        en = 1'b1;
        repeat (20) @(negedge clk);
        chk(flag, 1'b0);
        tx.glitch();
        repeat (100) @(negedge clk);
        chk(flag, 1'b0);
        snd(8'h81, 8, 1'b0, 1'b1);
        wait_flag();
        read();
        chk(d, 8'h81);
        $display("test 5 done");
        give_verdict();
    end
endmodule
`default_nettype wire
